// ===== sr256_pkg.sv
package sr256_pkg;

  localparam int SR256_ADDR_W = 8;
  localparam int SR256_DATA_W = 4;
  localparam int SR256_DEPTH = 256;

  // Timing at the 5 V supply, in nanoseconds.
  localparam int SR256_CLK_NS = 10;
  localparam int SR256_T_CYCLE_NS = 150;
  localparam int SR256_T_ACCESS_NS = 150;
  localparam int SR256_T_ODIS_NS = 70;
  localparam int SR256_T_FLOAT_MAX_NS = 70;
  localparam int SR256_T_WPULSE_NS = 70;
  localparam int SR256_T_SELWR_NS = 120;
  localparam int SR256_T_DSETUP_NS = 70;

  // Least times round up to whole cycles.
  localparam int SR256_CYC_CYCLE =
    (SR256_T_CYCLE_NS + SR256_CLK_NS - 1) / SR256_CLK_NS;
  localparam int SR256_CYC_ACCESS =
    (SR256_T_ACCESS_NS + SR256_CLK_NS - 1) / SR256_CLK_NS;
  localparam int SR256_CYC_ODIS =
    (SR256_T_ODIS_NS + SR256_CLK_NS - 1) / SR256_CLK_NS;
  localparam int SR256_CYC_FLOAT =
    (SR256_T_FLOAT_MAX_NS + SR256_CLK_NS - 1) / SR256_CLK_NS;
  localparam int SR256_CYC_WPULSE =
    (SR256_T_WPULSE_NS + SR256_CLK_NS - 1) / SR256_CLK_NS;
  localparam int SR256_CYC_SELWR =
    (SR256_T_SELWR_NS + SR256_CLK_NS - 1) / SR256_CLK_NS;
  localparam int SR256_CYC_DSETUP =
    (SR256_T_DSETUP_NS + SR256_CLK_NS - 1) / SR256_CLK_NS;

  localparam int SR256_CNT_W = 5;
  localparam logic [SR256_CNT_W-1:0] SR256_CNT_ZERO = 5'h00;

  typedef enum logic [2:0] {
    SR256_IDLE,
    SR256_WR_SETUP,
    SR256_WR_PULSE,
    SR256_WR_END,
    SR256_RD_WAIT,
    SR256_RD_FLOAT,
    SR256_RECOVER
  } sr256_state_t;

  // Pins that the controller drives towards the memory.
  typedef struct packed {
    logic select_low_active_n;
    logic select_high_active;
    logic read_not_write;
    logic output_disable;
    logic [SR256_ADDR_W-1:0] word_select;
    logic [SR256_DATA_W-1:0] write_data_in;
  } sr256_pins_t;

  // User request.
  typedef struct packed {
    logic valid;
    logic write;
    logic [SR256_ADDR_W-1:0] addr;
    logic [SR256_DATA_W-1:0] data;
  } sr256_req_t;

  typedef struct packed {
    sr256_state_t state;
    logic [SR256_CNT_W-1:0] cnt;
    logic [SR256_CNT_W-1:0] gap;
    sr256_pins_t pins;
    logic ready;
    logic done;
    logic [SR256_DATA_W-1:0] rdata;
    logic [SR256_DATA_W-1:0] q_s1;
    logic [SR256_DATA_W-1:0] q_s2;
  } sr256_regs_t;

  localparam sr256_pins_t SR256_PINS_IDLE = '{
    select_low_active_n: 1'b1,
    select_high_active: 1'b0,
    read_not_write: 1'b1,
    output_disable: 1'b1,
    word_select: 8'h00,
    write_data_in: 4'h0
  };

endpackage : sr256_pkg

// ===== sr256_host.sv
`timescale 1ns/1ps
// Behaviour
// RULE1 - Memory holds 256 four-bit words, addressed by an 8-bit word select.
// RULE2 - Device is selected only with low-active select low, high-active high.
// RULE3 - Low-active select high puts the device in standby, outputs floating.
// RULE4 - High-active select low puts the device in standby, outputs floating.
// RULE5 - Selected with direction low writes; output disable high floats outputs.
// RULE6 - Writing with output disable low, outputs echo the input data.
// RULE7 - Selected, direction high, output disable low: read drives valid data.
// RULE8 - Selected, direction high, output disable high: outputs stay floating.
// RULE9 - Separate buses: output disable free on writes, low on reads.
// RULE10 - Common bus: output disable high on writes, low on reads.
// RULE11 - Host spaces successive reads or writes by at least the cycle time.
// RULE12 - Host waits the address access delay before sampling read data.
// RULE13 - Host waits the output disable delay before trusting read outputs.
// RULE14 - Outputs float between minimum and maximum delay after being disabled.
// RULE15 - Host holds direction low at least the write pulse duration.
// RULE16 - Host keeps both selects asserted the minimum time before write end.
// RULE17 - Device stores input word when the write ends and keeps it.
// RULE18 - Host keeps the address stable for the whole write pulse.
module sr256_host
  import sr256_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // User request side
  input wire sr256_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [SR256_DATA_W-1:0] rsp_data,
  // Memory pins
  output sr256_pins_t mem,
  input wire logic [SR256_DATA_W-1:0] read_data_out
);

  sr256_regs_t r_q;
  sr256_regs_t r_d;

  // Output disable is held high across writes, so the controller also works
  // with data inputs and outputs tied together.
  always_comb begin
    r_d = r_q;
    r_d.done = 1'b0;
    r_d.q_s1 = read_data_out;
    r_d.q_s2 = r_q.q_s1;
    if (r_q.gap != SR256_CNT_ZERO) begin
      r_d.gap = r_q.gap - 5'h01;
    end
    if (r_q.cnt != SR256_CNT_ZERO) begin
      r_d.cnt = r_q.cnt - 5'h01;
    end
    unique case (r_q.state)
      SR256_IDLE: begin
        r_d.ready = (r_q.gap == SR256_CNT_ZERO);
        if (req.valid && r_q.ready) begin
          r_d.ready = 1'b0;
          r_d.pins.word_select = req.addr; // RULE1
          r_d.pins.write_data_in = req.data;
          r_d.pins.select_low_active_n = 1'b0; // RULE2
          r_d.pins.select_high_active = 1'b1; // RULE2
          r_d.gap = SR256_CNT_W'(SR256_CYC_CYCLE - 1); // RULE11
          if (req.write) begin
            r_d.pins.output_disable = 1'b1; // RULE10
            r_d.pins.read_not_write = 1'b1;
            r_d.state = SR256_WR_SETUP;
          end else begin
            r_d.pins.output_disable = 1'b0; // RULE9
            r_d.pins.read_not_write = 1'b1; // RULE7
            // The wait counts from issue, with two extra cycles for sampling.
            r_d.cnt = SR256_CNT_W'(SR256_CYC_ACCESS + 2); // RULE12
            r_d.state = SR256_RD_WAIT;
          end
        end
      end
      SR256_WR_SETUP: begin
        // Pulse length covers both pulse width and data set-up; select time
        // before the end of write sets the count, as it is the longest of the three.
        r_d.pins.read_not_write = 1'b0; // RULE5
        r_d.cnt = SR256_CNT_W'(SR256_CYC_SELWR - 1); // RULE16 RULE15
        r_d.state = SR256_WR_PULSE;
      end
      SR256_WR_PULSE: begin
        // Address and data stay put until the direction pin has risen.
        if (r_q.cnt == SR256_CNT_ZERO) begin // RULE18
          r_d.pins.read_not_write = 1'b1; // RULE17
          r_d.state = SR256_WR_END;
        end
      end
      SR256_WR_END: begin
        r_d.pins.select_low_active_n = 1'b1; // RULE3
        r_d.pins.select_high_active = 1'b0; // RULE4
        r_d.done = 1'b1;
        r_d.state = SR256_RECOVER;
      end
      SR256_RD_WAIT: begin
        // Two synchroniser stages add their delay on top of the access time.
        if (r_q.cnt == SR256_CNT_ZERO) begin // RULE13
          r_d.rdata = r_q.q_s2;
          r_d.done = 1'b1;
          r_d.pins.output_disable = 1'b1; // RULE8
          r_d.pins.select_low_active_n = 1'b1;
          r_d.pins.select_high_active = 1'b0;
          r_d.cnt = SR256_CNT_W'(SR256_CYC_FLOAT);
          r_d.state = SR256_RD_FLOAT;
        end
      end
      SR256_RD_FLOAT: begin
        // The next access waits until the bus has surely released.
        if (r_q.cnt == SR256_CNT_ZERO) begin // RULE14
          r_d.state = SR256_RECOVER;
        end
      end
      SR256_RECOVER: begin
        r_d.state = SR256_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      r_q <= '{
        state: SR256_IDLE,
        cnt: SR256_CNT_ZERO,
        gap: SR256_CNT_ZERO,
        pins: SR256_PINS_IDLE,
        ready: 1'b0,
        done: 1'b0,
        rdata: 4'h0,
        q_s1: 4'h0,
        q_s2: 4'h0
      };
    end else begin
      r_q <= r_d;
    end
  end

  assign req_ready = r_q.ready;
  assign rsp_valid = r_q.done;
  assign rsp_data = r_q.rdata;
  assign mem = r_q.pins;

endmodule // sr256_host

// ===== sr256_mem_model.sv
`timescale 1ns/1ps
module sr256_mem_model
  import sr256_pkg::*;
(
  // Pins from the host
  input wire sr256_pins_t mem,
  // Memory outputs
  output logic [SR256_DATA_W-1:0] read_data_out
);
  logic [SR256_DATA_W-1:0] arr [SR256_DEPTH];
  logic [SR256_DATA_W-1:0] wd, last;
  logic [SR256_ADDR_W-1:0] wa;
  logic sel, wr, drv;
  logic [SR256_DATA_W-1:0] val;
  assign sel = !mem.select_low_active_n && mem.select_high_active;
  assign wr = sel && !mem.read_not_write;
  assign drv = sel && !mem.output_disable;
  assign val = wr ? mem.write_data_in : arr[mem.word_select];
  always @* begin
    if (wr) begin
      wa = mem.word_select;
      wd = mem.write_data_in;
    end
  end
  always @(negedge wr) begin
    arr[wa] = wd;
  end
  always @* begin
    if (drv) begin
      last = val;
    end
  end
  // A floating bus shows the inverse so stale data never passes.
  assign #20 read_data_out = drv ? val : ~last;
endmodule // sr256_mem_model

// ===== sr256_host_props.sv
`timescale 1ns/1ps
module sr256_host_props
  import sr256_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Watched ports
  input wire sr256_req_t req,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [SR256_DATA_W-1:0] rsp_data,
  input wire sr256_pins_t mem,
  input wire logic [SR256_DATA_W-1:0] read_data_out
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  wire sel = !mem.select_low_active_n && mem.select_high_active;
  wr_guard_a: assert property (
    !mem.read_not_write |-> mem.output_disable && sel)
    else $error("write pulse unselected or outputs on");
  wr_pulse_a: assert property (
    $fell(mem.read_not_write) |-> !mem.read_not_write [*7])
    else $error("write pulse too short");
  wr_addr_a: assert property (
    (!mem.read_not_write ##1 !mem.read_not_write)
    |-> $stable(mem.word_select) && $stable(mem.write_data_in))
    else $error("address or data moved in write pulse");
  sel_wr_a: assert property (
    $rose(mem.read_not_write) |-> sel && $past(sel, 12))
    else $error("select too short before write end");
  rd_answer_a: assert property (
    $fell(mem.output_disable) |-> ##[15:25] rsp_valid)
    else $error("read answer out of window");
  rd_hold_a: assert property (
    $fell(mem.output_disable) |-> (!mem.output_disable && sel) [*8])
    else $error("read dropped too early");
  req_gap_a: assert property (
    req.valid && req_ready |=> !req_ready [*8])
    else $error("requests spaced too closely");
  bus_float_a: assert property (
    $rose(mem.output_disable) |-> mem.select_low_active_n [*7])
    else $error("reselect before outputs floated");
endmodule // sr256_host_props
bind sr256_host sr256_host_props i_props (.sys_clk(sys_clk), .srst(srst),
  .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .rsp_data(rsp_data), .mem(mem), .read_data_out(read_data_out));

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
  import sr256_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  sr256_req_t req = '0;
  logic req_ready, rsp_valid;
  logic [SR256_DATA_W-1:0] rsp_data, read_data_out;
  sr256_pins_t mem;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  sr256_host i_dut (.sys_clk(sys_clk), .srst(srst), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .mem(mem), .read_data_out(read_data_out));
  sr256_mem_model i_mem (.mem(mem), .read_data_out(read_data_out));
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Outputs are read before the edge's updates land, so values are settled.
  task automatic access(input logic wr, input logic [7:0] a,
    input logic [3:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    req <= {1'b1, wr, a, d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 100);
    req.valid <= 1'b0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 140);
    check({3'h0, rsp_valid}, 4'h1);
  endtask
  task automatic t_idle();
    check(mem[15:12], 4'hb);
  endtask
  task automatic t_bounds();
    access(1'b1, 8'h00, 4'h5);
    access(1'b1, 8'hff, 4'ha);
    access(1'b0, 8'h00, 4'h0);
    check(rsp_data, 4'h5);
    access(1'b0, 8'hff, 4'h0);
    check(rsp_data, 4'ha);
  endtask
  task automatic t_overwrite();
    access(1'b1, 8'h7f, 4'h3);
    access(1'b1, 8'h7f, 4'hc);
    access(1'b0, 8'h7f, 4'h0);
    check(rsp_data, 4'hc);
    access(1'b0, 8'h00, 4'h0);
    check(rsp_data, 4'h5);
  endtask
  task automatic t_patterns();
    for (int i = 0; i < 16; i++) begin
      access(1'b1, 8'h10 + 8'(i), 4'(i));
      access(1'b0, 8'h10 + 8'(i), 4'h0);
      check(rsp_data, 4'(i));
    end
  endtask
  // A reset in mid-write must leave the pins idle and the store intact.
  task automatic t_reset();
    int n;
    n = 0;
    @(posedge sys_clk);
    req <= {1'b1, 1'b1, 8'h42, 4'h9};
    do begin
      @(posedge sys_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 100);
    req.valid <= 1'b0;
    repeat (6) @(posedge sys_clk);
    srst <= 1'b1;
    repeat (8) @(posedge sys_clk);
    check(mem[15:12], 4'hb);
    check({rsp_valid, 2'h0, req_ready}, 4'h0);
    srst <= 1'b0;
    access(1'b0, 8'hff, 4'h0);
    check(rsp_data, 4'ha);
    access(1'b0, 8'h7f, 4'h0);
    check(rsp_data, 4'hc);
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      results();
    end
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    t_idle();
    t_bounds();
    t_overwrite();
    t_patterns();
    t_reset();
    results();
  end
endmodule // testbench
